//--- cache_cfg.svh
`ifndef CACHE_CFG_SVH
`define CACHE_CFG_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define STATUS_OFFSET    32'h0000_0000
`define ISOLATE_BIT      0
`define SWAP_BIT         1
`define MISS_BIT         2
`define LARGE_BIT        3
`define STATUS_RESET     32'h0000_0000

// ----------------------------------------------------------------------
// Cache geometry
// ----------------------------------------------------------------------
`define ICACHE_WORD_AW   11
`define ICACHE_LINE_AW   9
`define ICACHE_TAG_W     20
`define DCACHE_AW        9
`define DCACHE_TAG_W     21
`define DCACHE_ENT_W     54
`define ITAG_ENT_W       21
`define FULL_WORD_SEL    4'hf
`define ILINE_LAST       2'h3

`endif

//--- cache_pkg.sv
package cache_pkg;

    // Controller states, Gray coded in declaration order
    typedef enum logic [2:0] {
        st_idle = 3'h0,
        st_look = 3'h1,
        st_bus  = 3'h3,
        st_fill = 3'h2,
        st_resp = 3'h6
    } ctrl_state_type;

endpackage

//--- ram_port_if.sv
`timescale 1ns/1ps

interface ram_port_if #(
    parameter int AW = 9,
    parameter int DW = 32
);
    logic [AW-1:0] addr;
    logic          we;
    logic [DW-1:0] wdata;
    logic [DW-1:0] rdata;

    modport ctrl (output addr, output we, output wdata, input rdata);
    modport mem  (input addr, input we, input wdata, output rdata);
endinterface

//--- cache_ram.sv
`timescale 1ns/1ps

module cache_ram #(
    parameter int AW = 9,
    parameter int DW = 32
) (
    // Clock
    input  wire logic clock,
    // Array port
    ram_port_if.mem   port
);

    logic [DW-1:0] store [0:(1<<AW)-1];
    logic [DW-1:0] rdata_q;

    // Synchronous array, read data registered
    always_ff @(posedge clock) begin
        if (port.we) begin
            store[port.addr] <= port.wdata;
        end
        rdata_q <= store[port.addr];
    end

    assign port.rdata = rdata_q;

endmodule

//--- cache_swap_isolate_control.sv
// Decided for this implementation: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "cache_cfg.svh"

module cache_swap_isolate_control
    import cache_pkg::*;
#(
    parameter bit LARGE_ICACHE = 1'b1
) (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst_b,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [31:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Execution core requests
    input  wire logic        core_req,
    input  wire logic        core_fetch,
    input  wire logic        core_we,
    input  wire logic        core_cacheable,
    input  wire logic [3:0]  core_sel,
    input  wire logic [31:0] core_addr,
    input  wire logic [31:0] core_wdata,
    output logic             core_done,
    output logic      [31:0] core_rdata,
    // Bus interface unit
    output logic             biu_req,
    output logic             biu_we,
    output logic      [3:0]  biu_sel,
    output logic      [31:0] biu_addr,
    output logic      [31:0] biu_wdata,
    input  wire logic        biu_ack,
    input  wire logic [31:0] biu_rdata
);

    // ----------------------------------------------------------------------
    // Arrays
    // ----------------------------------------------------------------------
    ram_port_if #(.AW(`ICACHE_WORD_AW), .DW(32))          idat ();
    ram_port_if #(.AW(`ICACHE_LINE_AW), .DW(`ITAG_ENT_W))  itag ();
    ram_port_if #(.AW(`DCACHE_AW),      .DW(`DCACHE_ENT_W)) dent ();

    cache_ram #(.AW(`ICACHE_WORD_AW), .DW(32)) u_idat (.clock(clock), .port(idat));
    cache_ram #(.AW(`ICACHE_LINE_AW), .DW(`ITAG_ENT_W)) u_itag (.clock(clock), .port(itag));
    cache_ram #(.AW(`DCACHE_AW), .DW(`DCACHE_ENT_W)) u_dent (.clock(clock), .port(dent));

    // ----------------------------------------------------------------------
    // Status register
    // ----------------------------------------------------------------------
    logic        isolate_ctrl_q, isolate_ctrl_d;
    logic        swap_ctrl_q, swap_ctrl_d;
    logic        miss_flag_q, miss_flag_d;
    logic        ack_q, ack_d;
    logic [31:0] wb_dat_q, wb_dat_d;
    logic        miss_set;
    logic        miss_val;
    logic        wb_take;
    logic        status_hit;
    logic [31:0] status_word;

    assign wb_take    = wb_cyc_i & wb_stb_i & ~ack_q;
    assign status_hit = (wb_adr_i == `STATUS_OFFSET);

    // Status word image
    always_comb begin
        status_word = `STATUS_RESET;
        status_word[`ISOLATE_BIT] = isolate_ctrl_q;
        status_word[`SWAP_BIT]    = swap_ctrl_q;
        status_word[`MISS_BIT]    = miss_flag_q;
        status_word[`LARGE_BIT]   = LARGE_ICACHE;
    end

    // Bus slave next state
    always_comb begin
        ack_d          = wb_take;
        wb_dat_d       = wb_dat_q;
        isolate_ctrl_d = isolate_ctrl_q;
        swap_ctrl_d    = swap_ctrl_q;
        miss_flag_d    = miss_flag_q;
        if (wb_take) begin
            wb_dat_d = status_hit ? status_word : 32'h0000_0000;
        end
        // two separate control bits, written at the edge the master sees ack
        if (ack_q && wb_cyc_i && wb_stb_i && wb_we_i && status_hit && wb_sel_i[0]) begin
            isolate_ctrl_d = wb_dat_i[`ISOLATE_BIT];
            swap_ctrl_d    = wb_dat_i[`SWAP_BIT];
        end
        if (miss_set) begin
            miss_flag_d = miss_val;
        end
    end

    // Bus slave registers
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ack_q          <= 1'b0;
            wb_dat_q       <= 32'h0000_0000;
            isolate_ctrl_q <= 1'b0;
            swap_ctrl_q    <= 1'b0;
            miss_flag_q    <= 1'b0;
        end else begin
            ack_q          <= ack_d;
            wb_dat_q       <= wb_dat_d;
            isolate_ctrl_q <= isolate_ctrl_d;
            swap_ctrl_q    <= swap_ctrl_d;
            miss_flag_q    <= miss_flag_d;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = wb_dat_q;

    // ----------------------------------------------------------------------
    // Request controller
    // ----------------------------------------------------------------------
    ctrl_state_type state_q, state_d;
    logic        tgt_i_q, tgt_i_d;
    logic        we_q, we_d;
    logic [3:0]  sel_q, sel_d;
    logic [31:0] addr_q, addr_d;
    logic [31:0] wdata_q, wdata_d;
    logic [1:0]  cnt_q, cnt_d;
    logic [31:0] rdata_q, rdata_d;
    logic        breq_q, breq_d;
    logic        bwe_q, bwe_d;
    logic [3:0]  bsel_q, bsel_d;
    logic [31:0] baddr_q, baddr_d;
    logic [31:0] bwdata_q, bwdata_d;

    logic [31:0] la;
    logic [10:0] iword;
    logic        hit;
    logic [31:0] word;
    logic [31:0] merged;
    logic        full;
    logic        fill_last;

    // top index bit dropped on the small part so sizing addresses alias
    assign la    = (state_q == st_idle) ? core_addr : addr_q;
    assign iword = {LARGE_ICACHE & la[12], la[11:2]};
    assign full  = (sel_q == `FULL_WORD_SEL);

    // instruction side: one tag and valid bit per line; data side: per-word tag
    assign hit = tgt_i_q
        ? (itag.rdata[`ICACHE_TAG_W] && itag.rdata[`ICACHE_TAG_W-1:0] == addr_q[31:12])
        : (dent.rdata[`DCACHE_ENT_W-1] && dent.rdata[52:32] == addr_q[31:11]);
    assign word      = tgt_i_q ? idat.rdata : dent.rdata[31:0];
    assign fill_last = ~tgt_i_q | (cnt_q == `ILINE_LAST);

    for (genvar b = 0; b < 4; b++) begin : g_merge
        assign merged[8*b +: 8] = sel_q[b] ? wdata_q[8*b +: 8] : word[8*b +: 8];
    end

    // Array addressing and writes
    always_comb begin
        idat.addr  = (state_q == st_fill) ? {iword[10:2], cnt_q} : iword;
        itag.addr  = iword[10:2];
        dent.addr  = la[10:2];
        idat.we    = 1'b0;
        itag.we    = 1'b0;
        dent.we    = 1'b0;
        idat.wdata = wdata_q;
        itag.wdata = {1'b1, addr_q[31:12]};
        dent.wdata = {1'b1, addr_q[31:11], wdata_q};
        if (state_q == st_look && we_q) begin
            if (full) begin
                idat.we = tgt_i_q;
                itag.we = tgt_i_q;
                dent.we = ~tgt_i_q;
            end else if (isolate_ctrl_q) begin
                itag.we    = tgt_i_q;
                dent.we    = ~tgt_i_q;
                itag.wdata = {1'b0, itag.rdata[`ICACHE_TAG_W-1:0]};
                dent.wdata = {1'b0, dent.rdata[`DCACHE_ENT_W-2:0]};
            end else if (hit) begin
                idat.we    = tgt_i_q;
                dent.we    = ~tgt_i_q;
                idat.wdata = merged;
                dent.wdata = {dent.rdata[`DCACHE_ENT_W-1:32], merged};
            end
        end else if (state_q == st_fill && biu_ack) begin
            idat.we    = tgt_i_q;
            idat.wdata = biu_rdata;
            itag.we    = tgt_i_q & fill_last;
            dent.we    = ~tgt_i_q;
            dent.wdata = {1'b1, addr_q[31:11], biu_rdata};
        end
    end

    // Controller next state
    always_comb begin
        state_d  = state_q;
        tgt_i_d  = tgt_i_q;
        we_d     = we_q;
        sel_d    = sel_q;
        addr_d   = addr_q;
        wdata_d  = wdata_q;
        cnt_d    = cnt_q;
        rdata_d  = rdata_q;
        breq_d   = breq_q;
        bwe_d    = bwe_q;
        bsel_d   = bsel_q;
        baddr_d  = baddr_q;
        bwdata_d = bwdata_q;
        miss_set = 1'b0;
        miss_val = 1'b0;
        unique case (state_q)
            st_idle: begin
                if (core_req) begin
                    // swap exchanges the arrays of both sides
                    tgt_i_d = core_fetch ^ swap_ctrl_q;
                    we_d    = core_we & ~core_fetch;
                    sel_d   = core_sel;
                    addr_d  = core_addr;
                    wdata_d = core_wdata;
                    cnt_d   = 2'h0;
                    if (!core_cacheable) begin
                        // uncached reference goes to bus unit
                        state_d  = st_bus;
                        breq_d   = 1'b1;
                        bwe_d    = core_we & ~core_fetch;
                        bsel_d   = core_fetch ? `FULL_WORD_SEL : core_sel;
                        baddr_d  = core_addr;
                        bwdata_d = core_wdata;
                    end else begin
                        state_d = st_look;
                    end
                end
            end
            st_look: begin
                rdata_d = word;
                if (!we_q) begin
                    if (isolate_ctrl_q) begin
                        // isolated load always hits; record miss
                        miss_set = 1'b1;
                        miss_val = ~hit;
                        state_d  = st_resp;
                    end else if (hit) begin
                        state_d = st_resp;
                    end else begin
                        state_d  = st_fill;
                        breq_d   = 1'b1;
                        bwe_d    = 1'b0;
                        bsel_d   = `FULL_WORD_SEL;
                        baddr_d  = tgt_i_q ? {addr_q[31:4], 4'h0} : {addr_q[31:2], 2'h0};
                    end
                end else if (isolate_ctrl_q) begin
                    state_d = st_resp;
                end else begin
                    // memory sees the store as issued
                    state_d  = st_bus;
                    breq_d   = 1'b1;
                    bwe_d    = 1'b1;
                    bsel_d   = sel_q;
                    baddr_d  = addr_q;
                    bwdata_d = wdata_q;
                end
            end
            st_bus: begin
                if (biu_ack) begin
                    breq_d  = 1'b0;
                    rdata_d = biu_rdata;
                    state_d = st_resp;
                end
            end
            st_fill: begin
                if (biu_ack) begin
                    if (!tgt_i_q || cnt_q == addr_q[3:2]) begin
                        rdata_d = biu_rdata;
                    end
                    if (fill_last) begin
                        breq_d  = 1'b0;
                        state_d = st_resp;
                    end else begin
                        // whole line refilled before it is marked valid
                        cnt_d   = cnt_q + 2'h1;
                        baddr_d = {addr_q[31:4], cnt_q + 2'h1, 2'h0};
                    end
                end
            end
            st_resp: begin
                state_d = st_idle;
            end
        endcase
    end

    // Controller registers
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_q  <= st_idle;
            tgt_i_q  <= 1'b0;
            we_q     <= 1'b0;
            sel_q    <= 4'h0;
            addr_q   <= 32'h0000_0000;
            wdata_q  <= 32'h0000_0000;
            cnt_q    <= 2'h0;
            rdata_q  <= 32'h0000_0000;
            breq_q   <= 1'b0;
            bwe_q    <= 1'b0;
            bsel_q   <= 4'h0;
            baddr_q  <= 32'h0000_0000;
            bwdata_q <= 32'h0000_0000;
        end else begin
            state_q  <= state_d;
            tgt_i_q  <= tgt_i_d;
            we_q     <= we_d;
            sel_q    <= sel_d;
            addr_q   <= addr_d;
            wdata_q  <= wdata_d;
            cnt_q    <= cnt_d;
            rdata_q  <= rdata_d;
            breq_q   <= breq_d;
            bwe_q    <= bwe_d;
            bsel_q   <= bsel_d;
            baddr_q  <= baddr_d;
            bwdata_q <= bwdata_d;
        end
    end

    assign core_done  = (state_q == st_resp);
    assign core_rdata = rdata_q;
    assign biu_req    = breq_q;
    assign biu_we     = bwe_q;
    assign biu_sel    = bsel_q;
    assign biu_addr   = baddr_q;
    assign biu_wdata  = bwdata_q;

endmodule

//--- csic_chk.sv
`timescale 1ns/1ps
`include "cache_cfg.svh"

module csic_chk #(
    parameter bit LARGE_ICACHE = 1'b1
) (
    // Clock and reset
    input wire logic        clock,
    input wire logic        rst_b,
    // Register bus
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // Core and bus unit
    input wire logic        core_req,
    input wire logic        core_fetch,
    input wire logic        core_cacheable,
    input wire logic        core_done,
    input wire logic        biu_req,
    input wire logic        biu_we,
    input wire logic [31:0] biu_addr,
    input wire logic        biu_ack
);
    logic iso_q, iso_d, swp_q, swp_d, rd0_q, rd0_d;
    wire  take = wb_cyc_i && wb_stb_i && !wb_ack_o;

    // Shadow of the two control bits and of a status read
    always_comb begin
        rd0_d = take && !wb_we_i && wb_adr_i == `STATUS_OFFSET;
        {swp_d, iso_d} = {swp_q, iso_q};
        if (wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i
            && wb_adr_i == `STATUS_OFFSET && wb_sel_i[0]) begin
            {swp_d, iso_d} = {wb_dat_i[`SWAP_BIT], wb_dat_i[`ISOLATE_BIT]};
        end
    end

    // Shadow registers
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            {iso_q, swp_q, rd0_q} <= 3'h0;
        end else begin
            {iso_q, swp_q, rd0_q} <= {iso_d, swp_d, rd0_d};
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);

    AST_WB_ACK: assert property (take |=> wb_ack_o)
        else $error("register access not acked next cycle");
    AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    AST_STATUS: assert property (rd0_q |-> wb_dat_o[31:4] == 28'h0
        && wb_dat_o[3] == LARGE_ICACHE && wb_dat_o[1:0] == {swp_q, iso_q})
        else $error("status read value wrong");
    AST_BIU_HOLD: assert property (biu_req && !biu_ack |=>
        biu_req && $stable(biu_addr) && $stable(biu_we))
        else $error("bus request changed before ack");
    AST_BIU_NEXT: assert property (biu_req && biu_ack |=> core_done || biu_req)
        else $error("no answer after bus ack");
    AST_UNC_BUS: assert property ($rose(core_req) && !core_cacheable |=> biu_req)
        else $error("uncached reference not sent to bus");
    AST_ISO_NOBUS: assert property (iso_q && core_req && !core_fetch
        && core_cacheable |-> !biu_req)
        else $error("isolated data reference reached bus");
    AST_ISO_LAT: assert property ($rose(core_req) && iso_q && core_cacheable
        && !core_fetch |=> !core_done ##1 core_done)
        else $error("isolated reference not answered as hit");
    AST_DONE_ONE: assert property (core_done |=> !core_done)
        else $error("done longer than one cycle");
    AST_FETCH_RD: assert property (core_req && core_fetch && biu_req |-> !biu_we)
        else $error("fetch produced a bus write");
endmodule

bind cache_swap_isolate_control csic_chk #(.LARGE_ICACHE(LARGE_ICACHE)) csic_chk_i (.*);

//--- biu_model.sv
`timescale 1ns/1ps

module biu_model (
    // Clock and reset
    input wire logic        clock,
    input wire logic        rst_b,
    // Requests from the block, wait count from the bench
    input wire logic        biu_req,
    input wire logic        biu_we,
    input wire logic [3:0]  biu_sel,
    input wire logic [31:0] biu_addr,
    input wire logic [31:0] biu_wdata,
    input wire logic [3:0]  dly,
    // Answer
    output logic            biu_ack,
    output logic     [31:0] biu_rdata
);
    logic [31:0] mem [0:1023];
    logic [3:0]  wait_q;
    int          rd_n = 0;
    int          wr_n = 0;

    // Memory image is a plain function of the word index
    initial for (int i = 0; i < 1024; i++) mem[i] = 32'h1000_0000 + i;

    // One ack per beat after dly wait cycles; data line scrambled between answers
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            {biu_ack, wait_q, biu_rdata} <= '0;
        end else if (biu_req && !biu_ack && wait_q >= dly) begin
            biu_ack <= 1'b1;
            wait_q <= 4'h0;
            biu_rdata <= mem[biu_addr[11:2]];
            if (biu_we) begin
                wr_n++;
                // memory takes only the enabled bytes
                for (int b = 0; b < 4; b++) begin
                    if (biu_sel[b]) mem[biu_addr[11:2]][8*b +: 8] <= biu_wdata[8*b +: 8];
                end
            end else begin
                rd_n++;
            end
        end else begin
            biu_ack <= 1'b0;
            biu_rdata <= ~biu_rdata;
            wait_q <= (biu_req && !biu_ack) ? wait_q + 4'h1 : 4'h0;
        end
    end
endmodule

//--- tb_top.sv
`timescale 1ns/1ps
`include "cache_cfg.svh"

module tb_top;
    logic clock = 0, rst_b = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o;
    logic core_req = 0, core_fetch = 0, core_we = 0, core_cacheable = 0, core_done;
    logic biu_req, biu_we, biu_ack;
    logic [3:0] wb_sel_i = 4'h0, core_sel = 4'h0, biu_sel, dly = 4'h0;
    logic [31:0] wb_adr_i = 32'h0, wb_dat_i = 32'h0, wb_dat_o, core_addr = 32'h0;
    logic [31:0] core_wdata = 32'h0, core_rdata, biu_addr, biu_wdata, biu_rdata, rd_q;
    int err_total = 0, cmp_count = 0, r0;
    localparam logic [31:0] ISO = 32'h1 << `ISOLATE_BIT, SWP = 32'h1 << `SWAP_BIT;
    localparam logic [31:0] MISS = 32'h1 << `MISS_BIT, LRG = 32'h1 << `LARGE_BIT;

    cache_swap_isolate_control #(.LARGE_ICACHE(1'b1)) cache_swap_isolate_control_i (.*);
    biu_model biu_model_i (.*);

    // Clock
    always #12.5 clock = ~clock;

    // Memory image word for a byte address
    function automatic logic [31:0] mv(input logic [31:0] a);
        return 32'h1000_0000 + {22'h0, a[11:2]};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Classic single Wishbone cycle, result in rd_q
    task automatic wb(input logic we, input logic [31:0] a, input logic [31:0] d);
        @(posedge clock);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} <= {2'b11, we, 4'hf};
        {wb_adr_i, wb_dat_i} <= {a, d};
        // Only the watchdog ends a wait that never sees ack
        do begin
            @(posedge clock);
        end while (wb_ack_o !== 1'b1);
        rd_q = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask

    // One core reference held until done, result in rd_q
    task automatic op(input logic f, w, c, input logic [3:0] s, input logic [31:0] a, d);
        @(posedge clock);
        {core_req, core_fetch, core_we, core_cacheable, core_sel} <= {1'b1, f, w, c, s};
        {core_addr, core_wdata} <= {a, d};
        // Only the watchdog ends a wait that never sees done
        do begin
            @(posedge clock);
        end while (core_done !== 1'b1);
        rd_q = core_rdata;
        core_req <= 1'b0;
    endtask

    task automatic t_regs;
        wb(0, 32'h0, 32'h0);
        chk(rd_q, LRG);
        wb(1, 32'h0, 32'hffff_ffff);
        wb(0, 32'h0, 32'h0);
        chk(rd_q, ISO | SWP | LRG);
        wb(0, 32'h4, 32'h0);
        chk(rd_q, 32'h0);
        wb(1, 32'h0, 32'h0);
        $display("t_regs done");
    endtask

    // Code around control changes counts as uncached in this bench
    task automatic t_flush;
        wb(1, 32'h0, ISO);
        for (int i = 0; i < 512; i++) op(0, 1, 1, 4'h1, 32'(i * 4), 32'h0);
        wb(1, 32'h0, ISO | SWP);
        for (int i = 0; i < 512; i++) op(0, 1, 1, 4'h1, 32'(i * 16), 32'h0);
        wb(1, 32'h0, ISO);
        op(0, 0, 1, 4'hf, 32'h0, 32'h0);
        wb(0, 32'h0, 32'h0);
        chk(rd_q, ISO | MISS | LRG);
        chk(32'(biu_model_i.wr_n), 32'h0);
        $display("t_flush done");
    endtask

    task automatic t_iso;
        op(0, 1, 1, 4'hf, 32'h200, 32'hcafe_0001);
        op(0, 0, 1, 4'hf, 32'h200, 32'h0);
        chk(rd_q, 32'hcafe_0001);
        wb(0, 32'h0, 32'h0);
        chk(rd_q, ISO | LRG);
        op(0, 0, 1, 4'hf, 32'h204, 32'h0);
        wb(0, 32'h0, 32'h0);
        chk(rd_q, ISO | MISS | LRG);
        chk(32'(biu_model_i.wr_n), 32'h0);
        wb(1, 32'h0, 32'h0);
        $display("t_iso done");
    endtask

    task automatic t_unc;
        dly <= 4'h3;
        r0 = biu_model_i.rd_n;
        op(0, 0, 0, 4'hf, 32'h200, 32'h0);
        chk(rd_q, mv(32'h200));
        chk(32'(biu_model_i.rd_n - r0), 32'h1);
        op(0, 1, 0, 4'hf, 32'h44, 32'h1122_3344);
        chk(biu_model_i.mem[17], 32'h1122_3344);
        $display("t_unc done");
    endtask

    task automatic t_wt;
        dly <= 4'h1;
        op(0, 1, 1, 4'hf, 32'h80, 32'h5566_7788);
        chk(biu_model_i.mem[32], 32'h5566_7788);
        biu_model_i.mem[32] = 32'h0;
        op(0, 1, 1, 4'h2, 32'h80, 32'h0000_aa00);
        chk(biu_model_i.mem[32], 32'h0000_aa00);
        r0 = biu_model_i.rd_n;
        op(0, 0, 1, 4'hf, 32'h80, 32'h0);
        chk(rd_q, 32'h5566_aa88);
        chk(32'(biu_model_i.rd_n - r0), 32'h0);
        op(0, 1, 1, 4'h1, 32'h104, 32'h0000_00ee);
        chk(biu_model_i.mem[65], 32'h1000_00ee);
        op(0, 0, 1, 4'hf, 32'h104, 32'h0);
        chk(rd_q, 32'h1000_00ee);
        $display("t_wt done");
    endtask

    task automatic t_size;
        wb(1, 32'h0, ISO | SWP);
        op(1, 0, 1, 4'hf, 32'h200, 32'h0);
        chk(rd_q, 32'hcafe_0001);
        op(0, 1, 1, 4'hf, 32'h0000_0ffc, 32'h0000_00a1);
        op(0, 1, 1, 4'hf, 32'h0fff_fffc, 32'h0000_00b2);
        op(0, 0, 1, 4'hf, 32'h0000_0ffc, 32'h0);
        chk(rd_q, 32'h0000_00a1);
        wb(0, 32'h0, 32'h0);
        chk(rd_q, ISO | SWP | LRG);
        wb(1, 32'h0, ISO);
        op(0, 0, 1, 4'hf, 32'h0000_0ffc, 32'h0);
        wb(0, 32'h0, 32'h0);
        chk(rd_q, ISO | MISS | LRG);
        wb(1, 32'h0, 32'h0);
        $display("t_size done");
    endtask

    task automatic t_fetch;
        dly <= 4'h2;
        r0 = biu_model_i.rd_n;
        op(1, 0, 1, 4'hf, 32'h3004, 32'h0);
        chk(rd_q, mv(32'h3004));
        chk(32'(biu_model_i.rd_n - r0), 32'h4);
        op(1, 0, 1, 4'hf, 32'h300c, 32'h0);
        chk(rd_q, mv(32'h300c));
        chk(32'(biu_model_i.rd_n - r0), 32'h4);
        $display("t_fetch done");
    endtask

    task automatic print_verdict;
        $display("compares=%0d mismatches=%0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (8) @(posedge clock);
        rst_b <= 1'b1;
        t_regs;
        t_flush;
        t_iso;
        t_unc;
        t_wt;
        t_size;
        t_fetch;
        print_verdict;
    end

    // Watchdog, 40000 cycles, several times the length of the whole run
    initial begin
        #1_000_000;
        err_total++;
        print_verdict;
    end
endmodule
